// *** core/posp_pkg.sv ***
// Constants for the shared open-drain status pin logic.
// Assumes one 100 MHz core clock and a synchronous active-high reset.
package posp_pkg;
  localparam logic MODE_POWER_OK  = 1'b0;
  localparam logic MODE_INTERRUPT = 1'b1;
  localparam int   SYNC_STAGES    = 3;
  localparam int   NUM_IND        = 4;
  // Positions of the synchronised indications
  localparam int   IND_UV         = 0;
  localparam int   IND_SS         = 1;
  localparam int   IND_SHDN       = 2;
  localparam int   IND_FAULT      = 3;
  localparam logic [NUM_IND-1:0] IND_RESET = 4'h4;  // Shutdown assumed at reset
endpackage

// *** core/posp_status_pin.sv ***
// Status pin logic: power-ok indicator or latched interrupt request.
// Assumes analog indications are asynchronous; fault_read_in is a one-cycle
// pulse from the serial register block on the same clock.
// Assumes an external pull-up gives the high level; the pad only pulls low.
// Indications take about four edges through the synchroniser before they act.
`timescale 1ns/100ps
`default_nettype none
module posp_status_pin #(
  parameter logic PIN_MODE = posp_pkg::MODE_INTERRUPT
) (
  input  wire logic core_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic undervolt_in,      // Output below 93% of target
  input  wire logic soft_start_in,
  input  wire logic shutdown_in,
  input  wire logic fault_present_in,  // Any fault bit flagged
  input  wire logic fault_read_in,     // Fault register read pulse
  input  wire logic shared_status_pin_in,
  output logic      shared_status_pin_out,
  output logic      shared_status_pin_oe_out,
  output logic      irq_pending_out
);

  typedef struct packed {
    logic [posp_pkg::NUM_IND-1:0] s1;
    logic [posp_pkg::NUM_IND-1:0] s2;
    logic [posp_pkg::NUM_IND-1:0] s3;
    logic [posp_pkg::NUM_IND-1:0] ind;    // Debounced indications
    logic                         fault_q; // For rising edge of fault
    logic                         latch;   // Interrupt request latch
    logic                         pull;    // Pin pulled low
  } posp_state_t;

  posp_state_t st;
  posp_state_t next_st;
  logic [posp_pkg::NUM_IND-1:0] raw;
  logic uv, ss, sd, flt, flt_rise;

  assign raw = {fault_present_in, shutdown_in, soft_start_in, undervolt_in};

  // Next state: synchroniser, latch and pin decision
  always_comb begin
    next_st = st;
    next_st.s1 = raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < posp_pkg::NUM_IND; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.ind[i] = st.s3[i];  // Count only once two stages agree
      end
    end
    uv  = st.ind[posp_pkg::IND_UV];
    ss  = st.ind[posp_pkg::IND_SS];
    sd  = st.ind[posp_pkg::IND_SHDN];
    flt = st.ind[posp_pkg::IND_FAULT];
    flt_rise = flt && !st.fault_q;
    next_st.fault_q = flt;
    if (sd) begin
      next_st.latch = 1'b1;
    end else if (fault_read_in) begin
      next_st.latch = flt;  // read acknowledges
    end
    // new fault sets; set beats read
    if (flt_rise) begin
      next_st.latch = 1'b1;
    end
    if (PIN_MODE == posp_pkg::MODE_POWER_OK) begin
      next_st.pull = uv || ss || sd;
    end else begin
      next_st.pull = uv || next_st.latch;
    end
  end

  // State register
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      st       <= '0;
      st.s1    <= posp_pkg::IND_RESET;
      st.s2    <= posp_pkg::IND_RESET;
      st.s3    <= posp_pkg::IND_RESET;
      st.ind   <= posp_pkg::IND_RESET;
      st.latch <= 1'b1;
      st.pull  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign shared_status_pin_out    = 1'b0;
  assign shared_status_pin_oe_out = st.pull;
  assign irq_pending_out          = st.latch;

  // Assertions on the registered state.
  // The pin decision is registered, so most checks look one edge ahead
  // of the debounced indication that causes them.

  a_pin_never_high: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    shared_status_pin_oe_out |-> !shared_status_pin_out
  ) else $error("pin driven high");

  a_shutdown_pulls: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    st.ind[posp_pkg::IND_SHDN] |=> shared_status_pin_oe_out
  ) else $error("no pull in shutdown");

  a_uv_pulls: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    st.ind[posp_pkg::IND_UV] |=> shared_status_pin_oe_out
  ) else $error("no pull on undervolt");

  a_read_releases: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (fault_read_in && !st.ind[posp_pkg::IND_UV] && !st.ind[posp_pkg::IND_FAULT]
      && !st.ind[posp_pkg::IND_SHDN]) |=> !st.latch
  ) else $error("read did not clear");

  a_fault_persists: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (fault_read_in && st.ind[posp_pkg::IND_FAULT]) |=> st.latch
  ) else $error("fault lost");

  a_latch_holds: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (st.latch && !fault_read_in) |=> st.latch
  ) else $error("latch dropped unread");

  a_fault_sets: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (st.ind[posp_pkg::IND_FAULT] && !st.fault_q) |=> st.latch
  ) else $error("fault not latched");

  a_sync_delay: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (st.s2 == st.s3) |=> (st.ind == $past(st.s3))
  ) else $error("sync mismatch");

  a_pok_release: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (PIN_MODE == posp_pkg::MODE_POWER_OK && !st.ind[posp_pkg::IND_UV]
      && !st.ind[posp_pkg::IND_SS] && !st.ind[posp_pkg::IND_SHDN])
    |=> !shared_status_pin_oe_out
  ) else $error("power-ok not released");

  a_pok_softstart: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (PIN_MODE == posp_pkg::MODE_POWER_OK && st.ind[posp_pkg::IND_SS])
    |=> shared_status_pin_oe_out
  ) else $error("no pull in soft-start");

  a_shutdown_latch: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    st.ind[posp_pkg::IND_SHDN] |=> st.latch
  ) else $error("latch clear in shutdown");

  a_read_shutdown: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (fault_read_in && st.ind[posp_pkg::IND_SHDN]) |=> st.latch
  ) else $error("read cleared in shutdown");

  a_irq_release: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (PIN_MODE == posp_pkg::MODE_INTERRUPT && fault_read_in && st.ind == '0)
    |=> !shared_status_pin_oe_out
  ) else $error("interrupt pin not released");

  a_irq_follows: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (PIN_MODE == posp_pkg::MODE_INTERRUPT)
    |=> (shared_status_pin_oe_out == (st.latch || $past(st.ind[posp_pkg::IND_UV])))
  ) else $error("interrupt pin wrong");

  a_clear_by_read: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    $fell(st.latch) |-> $past(fault_read_in)
  ) else $error("latch cleared without read");

  a_set_beats_read: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (fault_read_in && st.ind[posp_pkg::IND_FAULT] && !st.fault_q) |=> st.latch
  ) else $error("read beat new fault");

  a_reset_pulls: assert property (
    @(posedge core_clk_in)
    $fell(sys_rst_in) |-> shared_status_pin_oe_out
  ) else $error("pin released after reset");

  // Main scenarios reached
  c_read_ack: cover property (
    @(posedge core_clk_in) st.latch ##1 fault_read_in ##1 !st.latch
  );

  c_fault_irq: cover property (
    @(posedge core_clk_in) !st.latch ##1 st.latch
  );

  c_release: cover property (
    @(posedge core_clk_in) shared_status_pin_oe_out ##1 !shared_status_pin_oe_out
  );

  c_persist_fault: cover property (
    @(posedge core_clk_in) (fault_read_in && st.ind[posp_pkg::IND_FAULT]) ##1 st.latch
  );

  c_pok_release: cover property (
    @(posedge core_clk_in) (PIN_MODE == posp_pkg::MODE_POWER_OK && st.pull) ##1 !st.pull
  );

endmodule
`default_nettype wire

// *** sim/posp_host.sv ***
// Host model: pull-up on the status pin and the fault register read strobe.
// Assumes the bench raises ack_in for exactly one clock per read.
`timescale 1ns/100ps
`default_nettype none
module posp_host (
  input  wire logic oe_in,
  input  wire logic drv_in,
  input  wire logic ack_in,
  output logic      pin_out,
  output logic      read_out
);
  assign pin_out = oe_in ? drv_in : 1'b1;
  assign read_out = ack_in;
endmodule
`default_nettype wire

// *** sim/posp_status_pin_bench.sv ***
// Bench: both part options side by side, each with its own host model.
// Assumes 100 MHz clock; inputs change 1 ns after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module posp_status_pin_bench;
  logic clk = 1'b0, rst = 1'b1, uv = 1'b0, ss = 1'b1, sd = 1'b1, flt = 1'b0, ack = 1'b0;
  logic [1:0] oe, drv, pin, rd, irq;
  int bad_count = 0, check_count = 0;
  // Index 0 power-ok option, index 1 interrupt option
  always #5 clk = ~clk;
  for (genvar g = 0; g < 2; g++) begin : g_mode
    posp_status_pin #(.PIN_MODE(logic'(g))) i_posp_status_pin (.core_clk_in(clk),
      .sys_rst_in(rst), .undervolt_in(uv), .soft_start_in(ss), .shutdown_in(sd),
      .fault_present_in(flt), .fault_read_in(rd[g]), .shared_status_pin_in(pin[g]),
      .shared_status_pin_out(drv[g]), .shared_status_pin_oe_out(oe[g]),
      .irq_pending_out(irq[g]));
    posp_host i_posp_host (.oe_in(oe[g]), .drv_in(drv[g]), .ack_in(ack),
      .pin_out(pin[g]), .read_out(rd[g]));
  end
  task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits n rising edges, then 1 ns so levels are settled
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd_pulse;
    ack = 1'b1;
    wt(1);
    ack = 1'b0;
    wt(2);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Start-up, undervoltage, faults, then a second shutdown
  initial begin
    wt(8);
    rst = 1'b0;
    wt(1);
    chk(drv, 2'h0);
    sd = 1'b0;
    wt(8);
    chk(pin, 2'h0);
    ss = 1'b0;
    wt(8);
    chk(pin, 2'h1);
    uv = 1'b1;
    wt(8);
    chk(pin, 2'h0);
    uv = 1'b0;
    wt(8);
    chk(pin, 2'h1);
    rd_pulse();
    chk(pin, 2'h3);
    chk(irq, 2'h0);
    flt = 1'b1;
    wt(8);
    chk(pin, 2'h1);
    chk(irq, 2'h3);
    rd_pulse();
    chk(pin, 2'h1);
    flt = 1'b0;
    wt(8);
    rd_pulse();
    wt(8);
    chk(pin, 2'h3);
    sd = 1'b1;
    wt(8);
    rd_pulse();
    chk(pin, 2'h0);
    report_and_stop();
  end
  // Hang guard well beyond the run length
  initial begin
    #20000;
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
